// ---- logic/can_rx_filter_overflow.sv ----
// Operation
// - Count zero or codes above seventeen compare no payload bits.
// - Count n compares from byte 1 bit 7; maximum code reaches filter bit 17.
// - Thirty-two overflow flags, buffers 0-15 low register, 16-31 high register.
// - A write directed to a full buffer sets that buffer's overflow flag.
// - Flags stay set until software clears; writes and reads only clear; reset is zero.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module can_rx_filter_overflow
(
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // Receive path
   input  wire logic        buf_write_in,
   input  wire logic [4:0]  buf_index_in,
   input  wire logic        buf_full_in,
   input  wire logic [17:0] payload_bits_in,
   input  wire logic [17:0] extended_identifier_filter_bits_in,
   // Filter result
   output logic             payload_compare_valid_out,
   output logic             payload_match_out,
   output logic [4:0]       payload_compare_bit_count_out,
   // Interrupt
   output logic             irq_out
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [31:0] rx_buffer_overflow_flag_q, rx_buffer_overflow_flag_d;
   logic [31:0] mask_q, mask_d;
   logic [4:0]  count_q, count_d;
   logic        aw_held_q, aw_held_d;
   logic [7:0]  aw_addr_q, aw_addr_d;
   logic        w_held_q, w_held_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0]  w_strb_q, w_strb_d;
   logic        bvalid_q, bvalid_d;
   logic [1:0]  bresp_q, bresp_d;
   logic        rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d;
   logic [31:0] hw_set, sw_clr, rd_clr;
   logic        wr_go, rd_go;

   default clocking sys_cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   function automatic logic [15:0] lane_mask(input logic [3:0] strb);
      lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == can_rx_filter_overflow_pkg::ADDR_PAYLOAD_FILTER_COUNT_CTRL)
               || (a == can_rx_filter_overflow_pkg::ADDR_RX_OVERFLOW_FLAGS_LOW)
               || (a == can_rx_filter_overflow_pkg::ADDR_RX_OVERFLOW_FLAGS_HIGH)
               || (a == can_rx_filter_overflow_pkg::ADDR_IRQ_MASK_LOW)
               || (a == can_rx_filter_overflow_pkg::ADDR_IRQ_MASK_HIGH)
               || (a == can_rx_filter_overflow_pkg::ADDR_COUNT_SETTING);
   endfunction

   // ****************************************************************
   // Bus handshake
   // ****************************************************************
   assign s_axi_awready_out = !aw_held_q && !bvalid_q;
   assign s_axi_wready_out  = !w_held_q && !bvalid_q;
   assign s_axi_arready_out = !rvalid_q;
   assign s_axi_bvalid_out  = bvalid_q;
   assign s_axi_bresp_out   = bresp_q;
   assign s_axi_rvalid_out  = rvalid_q;
   assign s_axi_rdata_out   = rdata_q;
   assign s_axi_rresp_out   = rresp_q;
   assign wr_go             = aw_held_q && w_held_q && !bvalid_q;
   assign rd_go             = s_axi_arvalid_in && !rvalid_q;

   always_comb
   begin
      aw_held_d = aw_held_q;
      aw_addr_d = aw_addr_q;
      w_held_d  = w_held_q;
      w_data_d  = w_data_q;
      w_strb_d  = w_strb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      count_d   = count_q;
      mask_d    = mask_q;
      sw_clr    = 32'h0000_0000;
      rd_clr    = 32'h0000_0000;
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
         aw_held_d = 1'b1;
         aw_addr_d = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
         w_held_d = 1'b1;
         w_data_d = s_axi_wdata_in;
         w_strb_d = s_axi_wstrb_in;
      end
      if (wr_go)
      begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = is_mapped(aw_addr_q) ? can_rx_filter_overflow_pkg::RESP_OKAY
                                          : can_rx_filter_overflow_pkg::RESP_SLVERR;
         if (aw_addr_q == can_rx_filter_overflow_pkg::ADDR_RX_OVERFLOW_FLAGS_LOW)
         begin
            sw_clr[15:0] = w_data_q[15:0] & lane_mask(w_strb_q);
         end
         else if (aw_addr_q == can_rx_filter_overflow_pkg::ADDR_RX_OVERFLOW_FLAGS_HIGH)
         begin
            sw_clr[31:16] = w_data_q[15:0] & lane_mask(w_strb_q);
         end
         else if (aw_addr_q == can_rx_filter_overflow_pkg::ADDR_IRQ_MASK_LOW)
         begin
            mask_d[15:0] = (mask_q[15:0] & ~lane_mask(w_strb_q))
                         | (w_data_q[15:0] & lane_mask(w_strb_q));
         end
         else if (aw_addr_q == can_rx_filter_overflow_pkg::ADDR_IRQ_MASK_HIGH)
         begin
            mask_d[31:16] = (mask_q[31:16] & ~lane_mask(w_strb_q))
                          | (w_data_q[15:0] & lane_mask(w_strb_q));
         end
         else if ((aw_addr_q == can_rx_filter_overflow_pkg::ADDR_COUNT_SETTING) && w_strb_q[0])
         begin
            count_d = w_data_q[4:0];
         end
      end
      if (bvalid_q && s_axi_bready_in)
      begin
         bvalid_d = 1'b0;
      end
      if (rvalid_q && s_axi_rready_in)
      begin
         rvalid_d = 1'b0;
      end
      if (rd_go)
      begin
         rvalid_d = 1'b1;
         rdata_d  = 32'h0000_0000;
         rresp_d  = can_rx_filter_overflow_pkg::RESP_OKAY;
         if ((s_axi_araddr_in == can_rx_filter_overflow_pkg::ADDR_PAYLOAD_FILTER_COUNT_CTRL)
             || (s_axi_araddr_in == can_rx_filter_overflow_pkg::ADDR_COUNT_SETTING))
         begin
            rdata_d[4:0] = count_q;
         end
         else if (s_axi_araddr_in == can_rx_filter_overflow_pkg::ADDR_RX_OVERFLOW_FLAGS_LOW)
         begin
            rdata_d[15:0] = rx_buffer_overflow_flag_q[15:0];
            rd_clr[15:0]  = rx_buffer_overflow_flag_q[15:0];
         end
         else if (s_axi_araddr_in == can_rx_filter_overflow_pkg::ADDR_RX_OVERFLOW_FLAGS_HIGH)
         begin
            rdata_d[15:0] = rx_buffer_overflow_flag_q[31:16];
            rd_clr[31:16] = rx_buffer_overflow_flag_q[31:16];
         end
         else if (s_axi_araddr_in == can_rx_filter_overflow_pkg::ADDR_IRQ_MASK_LOW)
         begin
            rdata_d[15:0] = mask_q[15:0];
         end
         else if (s_axi_araddr_in == can_rx_filter_overflow_pkg::ADDR_IRQ_MASK_HIGH)
         begin
            rdata_d[15:0] = mask_q[31:16];
         end
         else
         begin
            rresp_d = can_rx_filter_overflow_pkg::RESP_SLVERR;
         end
      end
   end

   // ****************************************************************
   // Overflow flags
   // ****************************************************************
   always_comb
   begin
      hw_set = 32'h0000_0000;
      if (buf_write_in && buf_full_in)
      begin
         hw_set[buf_index_in] = 1'b1;
      end
      rx_buffer_overflow_flag_d = (rx_buffer_overflow_flag_q & ~(sw_clr | rd_clr))
                                | hw_set;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rx_buffer_overflow_flag_q <= {can_rx_filter_overflow_pkg::FLAGS_RESET,
                                       can_rx_filter_overflow_pkg::FLAGS_RESET};
         mask_q    <= {can_rx_filter_overflow_pkg::MASK_RESET,
                       can_rx_filter_overflow_pkg::MASK_RESET};
         count_q   <= can_rx_filter_overflow_pkg::COUNT_RESET;
         aw_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_held_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'b00;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= 2'b00;
      end
      else
      begin
         rx_buffer_overflow_flag_q <= rx_buffer_overflow_flag_d;
         mask_q    <= mask_d;
         count_q   <= count_d;
         aw_held_q <= aw_held_d;
         aw_addr_q <= aw_addr_d;
         w_held_q  <= w_held_d;
         w_data_q  <= w_data_d;
         w_strb_q  <= w_strb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   assign irq_out = |(rx_buffer_overflow_flag_q & mask_q);
   assign payload_compare_bit_count_out = count_q;

   // ****************************************************************
   // Payload compare
   // ****************************************************************
   payload_compare u_payload_compare
   (
      .count_in        (count_q),
      .payload_bits_in (payload_bits_in),
      .filter_bits_in  (extended_identifier_filter_bits_in),
      .valid_out       (payload_compare_valid_out),
      .match_out       (payload_match_out)
   );

   // ****************************************************************
   // Assertions
   // ****************************************************************
   AST_NO_COMPARE: assert property ((count_q == can_rx_filter_overflow_pkg::COUNT_NONE)
      || (count_q > can_rx_filter_overflow_pkg::COUNT_MAX)
      |-> (!payload_compare_valid_out && payload_match_out))
      else $error("Compare active for zero or invalid count");
   AST_ONE_BIT: assert property ((count_q == 5'h01) |->
      (payload_match_out == (payload_bits_in[0] == extended_identifier_filter_bits_in[0])))
      else $error("Count one does not compare bit zero");
   AST_MAX_BITS: assert property ((count_q == can_rx_filter_overflow_pkg::COUNT_MAX) |->
      (payload_match_out == (payload_bits_in == extended_identifier_filter_bits_in)))
      else $error("Maximum count does not compare all bits");
   AST_HIGH_MAP: assert property (
      (rd_go && (s_axi_araddr_in == can_rx_filter_overflow_pkg::ADDR_RX_OVERFLOW_FLAGS_HIGH))
      |=> (s_axi_rdata_out[15:0] == $past(rx_buffer_overflow_flag_q[31:16])))
      else $error("High buffer flags not shown in high register");
   AST_SET_ON_FULL: assert property ((buf_write_in && buf_full_in) |=>
      rx_buffer_overflow_flag_q[$past(buf_index_in)])
      else $error("Overflow flag not set on write to full buffer");
   AST_NO_SPURIOUS: assert property ($rose(|rx_buffer_overflow_flag_q) |->
      $past(buf_write_in && buf_full_in))
      else $error("Overflow flag set without cause");
   AST_STICKY: assert property ((rx_buffer_overflow_flag_q[0] && !wr_go && !rd_go) |=>
      rx_buffer_overflow_flag_q[0])
      else $error("Overflow flag dropped without clear");
   AST_SET_WINS: assert property ((wr_go || rd_go) && buf_write_in && buf_full_in |=>
      rx_buffer_overflow_flag_q[$past(buf_index_in)])
      else $error("Clear beat a simultaneous set");
   AST_IRQ: assert property (buf_write_in && buf_full_in && mask_q[buf_index_in] && !wr_go
      |=> irq_out)
      else $error("Interrupt not raised for unmasked overflow");

endmodule

`default_nettype wire

// ---- logic/can_rx_filter_overflow_pkg.sv ----
package can_rx_filter_overflow_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_PAYLOAD_FILTER_COUNT_CTRL = 8'h00;
   localparam logic [7:0] ADDR_RX_OVERFLOW_FLAGS_LOW     = 8'h04;
   localparam logic [7:0] ADDR_RX_OVERFLOW_FLAGS_HIGH    = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK_LOW              = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK_HIGH             = 8'h10;
   localparam logic [7:0] ADDR_COUNT_SETTING             = 8'h14;

   // ****************************************************************
   // Fields and values
   // ****************************************************************
   localparam int          COUNT_W         = 5;
   localparam int          NUM_BUFFERS     = 32;
   localparam int          HALF_BUFFERS    = 16;
   localparam int          EID_W           = 18;
   localparam logic [4:0]  COUNT_NONE      = 5'h00;
   localparam logic [4:0]  COUNT_MAX       = 5'h11;
   localparam logic [4:0]  COUNT_RESET     = 5'h00;
   localparam logic [15:0] FLAGS_RESET     = 16'h0000;
   localparam logic [15:0] MASK_RESET      = 16'h0000;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;

endpackage

// ---- logic/payload_compare.sv ----
`timescale 1ns/1ps
`default_nettype none

module payload_compare
(
   // Setting
   input  wire logic [4:0]  count_in,
   // Payload bits in compare order and filter bits
   input  wire logic [17:0] payload_bits_in,
   input  wire logic [17:0] filter_bits_in,
   // Result
   output logic             valid_out,
   output logic             match_out
);

   logic [17:0] enable;

   always_comb
   begin
      enable = 18'h0_0000;
      for (int i = 0; i < can_rx_filter_overflow_pkg::EID_W; i++)
      begin
         if ((count_in <= can_rx_filter_overflow_pkg::COUNT_MAX) && (i < int'(count_in)))
         begin
            enable[i] = 1'b1;
         end
      end
      if (count_in == can_rx_filter_overflow_pkg::COUNT_MAX)
      begin
         enable[can_rx_filter_overflow_pkg::EID_W - 1] = 1'b1;
      end
   end

   assign valid_out = (count_in != can_rx_filter_overflow_pkg::COUNT_NONE)
                    && (count_in <= can_rx_filter_overflow_pkg::COUNT_MAX);
   assign match_out = ((payload_bits_in ^ filter_bits_in) & enable) == 18'h0_0000;

endmodule

`default_nettype wire

// ---- verif/can_rx_path_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module can_rx_path_model
(
   // Clock
   input  wire logic        clk_sys_in,
   // Receive buffer write
   output logic             buf_write_out,
   output logic [4:0]       buf_index_out,
   output logic             buf_full_out,
   // Message and filter bits
   output logic [17:0]      payload_bits_out,
   output logic [17:0]      filter_bits_out
);

   // ********
   // Receive path
   // ********
   initial
   begin
      buf_write_out    = 1'h0;
      buf_index_out    = 5'h00;
      buf_full_out     = 1'h0;
      payload_bits_out = 18'h0_0000;
      filter_bits_out  = 18'h0_0000;
   end

   // One buffer write, then index and full lines turn over
   task automatic put(input logic [4:0] idx, input logic full);
      buf_write_out <= 1'h1;
      buf_index_out <= idx;
      buf_full_out  <= full;
      @(posedge clk_sys_in);
      buf_write_out <= 1'h0;
      buf_index_out <= ~idx;
      buf_full_out  <= ~full;
      @(posedge clk_sys_in);
   endtask

   task automatic set_bits(input logic [17:0] pay, input logic [17:0] filt);
      payload_bits_out <= pay;
      filter_bits_out  <= filt;
   endtask

endmodule

`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;

   // ********
   // Signals
   // ********
   localparam logic [7:0] CTRL = can_rx_filter_overflow_pkg::ADDR_PAYLOAD_FILTER_COUNT_CTRL;
   localparam logic [7:0] CNT  = can_rx_filter_overflow_pkg::ADDR_COUNT_SETTING;
   localparam logic [7:0] LO   = can_rx_filter_overflow_pkg::ADDR_RX_OVERFLOW_FLAGS_LOW;
   localparam logic [7:0] HI   = can_rx_filter_overflow_pkg::ADDR_RX_OVERFLOW_FLAGS_HIGH;
   localparam logic [7:0] MLO  = can_rx_filter_overflow_pkg::ADDR_IRQ_MASK_LOW;
   localparam logic [7:0] MHI  = can_rx_filter_overflow_pkg::ADDR_IRQ_MASK_HIGH;
   localparam logic [1:0] OK   = can_rx_filter_overflow_pkg::RESP_OKAY;
   localparam logic [1:0] ERR  = can_rx_filter_overflow_pkg::RESP_SLVERR;
   logic        clk_sys = 1'h0;
   logic        rst_n = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid, bwr, bfull, cvalid, match, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [4:0]  bidx, count;
   logic [17:0] pay, filt, m;
   int          errors = 0;
   int          cmp_count = 0;
   int          cycles = 0;

   always #2.5 clk_sys = ~clk_sys;

   can_rx_filter_overflow u_can_rx_filter_overflow
   (
      .clk_sys_in                         (clk_sys),
      .rst_n_in                           (rst_n),
      .s_axi_awaddr_in                    (awaddr),
      .s_axi_awvalid_in                   (awvalid),
      .s_axi_awready_out                  (awready),
      .s_axi_wdata_in                     (wdata),
      .s_axi_wstrb_in                     (wstrb),
      .s_axi_wvalid_in                    (wvalid),
      .s_axi_wready_out                   (wready),
      .s_axi_bresp_out                    (bresp),
      .s_axi_bvalid_out                   (bvalid),
      .s_axi_bready_in                    (bready),
      .s_axi_araddr_in                    (araddr),
      .s_axi_arvalid_in                   (arvalid),
      .s_axi_arready_out                  (arready),
      .s_axi_rdata_out                    (rdata),
      .s_axi_rresp_out                    (rresp),
      .s_axi_rvalid_out                   (rvalid),
      .s_axi_rready_in                    (rready),
      .buf_write_in                       (bwr),
      .buf_index_in                       (bidx),
      .buf_full_in                        (bfull),
      .payload_bits_in                    (pay),
      .extended_identifier_filter_bits_in (filt),
      .payload_compare_valid_out          (cvalid),
      .payload_match_out                  (match),
      .payload_compare_bit_count_out      (count),
      .irq_out                            (irq)
   );

   can_rx_path_model u_part
   (
      .clk_sys_in       (clk_sys),
      .buf_write_out    (bwr),
      .buf_index_out    (bidx),
      .buf_full_out     (bfull),
      .payload_bits_out (pay),
      .filter_bits_out  (filt)
   );

   // ********
   // Tasks
   // ********
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                     input logic [1:0] er);
      awaddr  <= a;
      awvalid <= 1'h1;
      wdata   <= v;
      wstrb   <= s;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      do
      begin
         @(posedge clk_sys);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
      end
      while (!(bvalid && bready));
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      bready <= 1'h0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do
      begin
         @(posedge clk_sys);
         if (arvalid && arready)
            arvalid <= 1'h0;
      end
      while (!(rvalid && rready));
      chk("rdata", rdata, exp);
      chk("rresp", {30'h0, rresp}, {30'h0, er});
      rready <= 1'h0;
      @(posedge clk_sys);
   endtask

   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         errors++;
         end_sim;
      end
   end

   // ********
   // Tests
   // ********
   initial
   begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'h1;
      @(posedge clk_sys);
      chk("irq", {31'h0, irq}, 32'h0);
      for (int i = 0; i < 6; i++)
         rd(8'(4 * i), 32'h0000_0000, OK);
      rd(8'h18, 32'h0000_0000, ERR);
      wr(8'h1C, 32'h0000_FFFF, 4'hF, ERR);
      $display("test reset done");
      for (int c = 0; c < 32; c++)
      begin
         wr(CNT, 32'(c), 4'h1, OK);
         rd(CTRL, 32'(c), OK);
         m = (c >= 1 && c <= 16) ? 18'((1 << c) - 1) : 18'h0_0000;
         if (c == 17)
            m = 18'h3_FFFF;
         u_part.set_bits(18'h0_0000, ~m);
         @(negedge clk_sys);
         chk("count", {27'h0, count}, 32'(c));
         chk("valid", {31'h0, cvalid}, {31'h0, m[0]});
         chk("match", {31'h0, match}, 32'h1);
         if (m[0])
         begin
            @(posedge clk_sys);
            u_part.set_bits(18'h0_0000, 18'(1 << ((c == 17) ? 17 : c - 1)));
            @(negedge clk_sys);
            chk("match", {31'h0, match}, 32'h0);
         end
         @(posedge clk_sys);
      end
      wr(CTRL, 32'h0000_0003, 4'hF, OK);
      rd(CTRL, 32'h0000_001F, OK);
      $display("test count done");
      u_part.put(5'h00, 1'h1);
      u_part.put(5'h0F, 1'h1);
      u_part.put(5'h10, 1'h1);
      u_part.put(5'h1F, 1'h1);
      u_part.put(5'h03, 1'h0);
      rd(LO, 32'h0000_8001, OK);
      rd(HI, 32'h0000_8001, OK);
      rd(LO, 32'h0000_0000, OK);
      u_part.put(5'h02, 1'h1);
      u_part.put(5'h05, 1'h1);
      wr(LO, 32'h0000_0104, 4'hF, OK);
      wr(LO, 32'h0000_0020, 4'h2, OK);
      wr(LO, 32'h0000_0000, 4'hF, OK);
      rd(LO, 32'h0000_0020, OK);
      $display("test flags done");
      u_part.put(5'h07, 1'h1);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(MLO, 32'h0000_0080, 4'hF, OK);
      rd(MLO, 32'h0000_0080, OK);
      chk("irq", {31'h0, irq}, 32'h1);
      rd(LO, 32'h0000_0080, OK);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(MHI, 32'h0000_0010, 4'hF, OK);
      u_part.put(5'h14, 1'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      rd(HI, 32'h0000_0010, OK);
      $display("test irq done");
      u_part.put(5'h09, 1'h1);
      fork
         u_part.put(5'h09, 1'h1);
         rd(LO, 32'h0000_0200, OK);
      join
      rd(LO, 32'h0000_0200, OK);
      rd(LO, 32'h0000_0000, OK);
      fork
         begin
            @(posedge clk_sys);
            u_part.put(5'h09, 1'h1);
         end
         wr(LO, 32'h0000_0200, 4'hF, OK);
      join
      rd(LO, 32'h0000_0200, OK);
      $display("test collision done");
      end_sim;
   end

endmodule

`default_nettype wire
